// ### pkg/salp_map.vh
// Register map, field positions, reset values and codes of the automatic
// low-power timer. Included by the design files by its bare name.
`ifndef SALP_MAP_VH
`define SALP_MAP_VH

`define SALP_ADDR_W 8
`define SALP_PMC_OFFSET 8'h00
`define SALP_STAT_OFFSET 8'h04

`define SALP_PMC_RESET 32'h00000000
`define SALP_PD_THR_LSB 12
`define SALP_PD_THR_MSB 15
`define SALP_LP_SEL_LSB 8
`define SALP_LP_SEL_MSB 10
`define SALP_SR_THR_LSB 4
`define SALP_SR_THR_MSB 7

`define SALP_LP_SEL_SR 3'h2
`define SALP_LP_SEL_PD 3'h4

`define SALP_THR_W 4
`define SALP_CNT_W 19
`define SALP_THR_BASE 19'h00008

`define SALP_EXIT_CYCLES 4

`define SALP_RESP_OKAY 2'h0
`define SALP_RESP_SLVERR 2'h2

`endif

// ### rtl/salp_idle_timer.v
// Idle counter with the threshold code decode shared by both low-power modes.
// Assumes the caller holds i_clear high while any access is pending or the
// memory is not in the active state.
`timescale 1ns/1ps
`default_nettype none
`include "salp_map.vh"

module salp_idle_timer #(
  parameter CNT_W = `SALP_CNT_W
) (
  // Clock, reset and enable.
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  // Control.
  input wire i_clear,
  input wire [`SALP_THR_W-1:0] i_code,
  // Status.
  output wire o_reached
);

////////////////////////////////////////////////////////////////////////////////

  reg [CNT_W-1:0] idle_count;
  wire [CNT_W-1:0] threshold;
  wire count_full;

  // Code 0 is immediate, otherwise 16 doubled per step; code 10 gives 8192.
  assign threshold = (i_code == 4'h0) ? {CNT_W{1'b0}} :
    (`SALP_THR_BASE << i_code);
  assign count_full = &idle_count;
  assign o_reached = (idle_count >= threshold);

  // Saturating, so a long idle stretch never wraps back below the threshold.
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
      idle_count <= {CNT_W{1'b0}};
    else if (i_ce)
    begin
      if (i_clear)
        idle_count <= {CNT_W{1'b0}};
      else if (!count_full)
        idle_count <= idle_count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // salp_idle_timer

`default_nettype wire

// ### rtl/salp_top.v
// Automatic low-power timer of an SDRAM controller with its AXI4-Lite
// control register. Assumes the controller reports pending accesses on
// i_access_pending and issues commands only while o_cmd_allow is high.
`timescale 1ns/1ps
`default_nettype none
`include "salp_map.vh"

module salp_top #(
  parameter EXIT_CYCLES = `SALP_EXIT_CYCLES
) (
  // Clock, reset and enable.
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  // AXI4-Lite write address and data.
  input wire [`SALP_ADDR_W-1:0] i_s_axi_awaddr,
  input wire [2:0] i_s_axi_awprot,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  // AXI4-Lite write response.
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  // AXI4-Lite read.
  input wire [`SALP_ADDR_W-1:0] i_s_axi_araddr,
  input wire [2:0] i_s_axi_arprot,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  // Controller side.
  input wire i_access_pending,
  output reg o_cmd_allow,
  output reg o_powerdown,
  output reg o_selfrefresh
);

////////////////////////////////////////////////////////////////////////////////

  localparam ST_ACTIVE = 2'h0;
  localparam ST_PD = 2'h1;
  localparam ST_SR = 2'h2;
  localparam ST_EXIT = 2'h3;
  localparam [31:0] PMC_RST = `SALP_PMC_RESET;

  reg [3:0] pd_thr;
  reg [2:0] lp_sel;
  reg [3:0] sr_thr;
  reg [`SALP_ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [3:0] exit_count;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  wire [31:0] pmc_value;
  wire [31:0] stat_value;
  wire aw_hs;
  wire w_hs;
  wire b_hs;
  wire ar_hs;
  wire r_hs;
  wire wr_fire;
  wire sel_sr;
  wire sel_pd;
  wire sel_on;
  wire idle_clear;
  wire reached;
  wire exit_done;

  assign aw_hs = i_s_axi_awvalid && o_s_axi_awready;
  assign w_hs = i_s_axi_wvalid && o_s_axi_wready;
  assign b_hs = o_s_axi_bvalid && i_s_axi_bready;
  assign ar_hs = i_s_axi_arvalid && o_s_axi_arready;
  assign r_hs = o_s_axi_rvalid && i_s_axi_rready;
  assign wr_fire = !o_s_axi_awready && !o_s_axi_wready && !o_s_axi_bvalid;

  // Reserved positions are not stored at all, so they can only read zero.
  assign pmc_value = {16'h0000, pd_thr, 1'b0, lp_sel, sr_thr, 4'h0};
  assign stat_value = {27'h0000000, o_cmd_allow, o_selfrefresh, o_powerdown, state};

  assign sel_sr = (lp_sel == `SALP_LP_SEL_SR);
  assign sel_pd = (lp_sel == `SALP_LP_SEL_PD);
  assign sel_on = sel_sr || sel_pd;
  assign idle_clear = i_access_pending || (state != ST_ACTIVE) || !sel_on;
  assign exit_done = (exit_count == 4'h0);

////////////////////////////////////////////////////////////////////////////////

  salp_idle_timer u_idle_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_clear(idle_clear),
    .i_code(sel_sr ? sr_thr : pd_thr),
    .o_reached(reached)
  );

////////////////////////////////////////////////////////////////////////////////

  // Write channel: address and data are taken in either order and the
  // register is updated at the edge that raises the response.
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `SALP_RESP_OKAY;
      aw_addr <= {`SALP_ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      pd_thr <= PMC_RST[`SALP_PD_THR_MSB:`SALP_PD_THR_LSB];
      lp_sel <= PMC_RST[`SALP_LP_SEL_MSB:`SALP_LP_SEL_LSB];
      sr_thr <= PMC_RST[`SALP_SR_THR_MSB:`SALP_SR_THR_LSB];
    end
    else if (i_ce)
    begin
      if (aw_hs)
      begin
        aw_addr <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (w_hs)
      begin
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        o_s_axi_bvalid <= 1'b1;
        if ({aw_addr[`SALP_ADDR_W-1:2], 2'b00} == `SALP_PMC_OFFSET)
        begin
          o_s_axi_bresp <= `SALP_RESP_OKAY;
          if (w_strb[1])
          begin
            pd_thr <= w_data[`SALP_PD_THR_MSB:`SALP_PD_THR_LSB];
            lp_sel <= w_data[`SALP_LP_SEL_MSB:`SALP_LP_SEL_LSB];
          end
          if (w_strb[0])
            sr_thr <= w_data[`SALP_SR_THR_MSB:`SALP_SR_THR_LSB];
        end
        else if ({aw_addr[`SALP_ADDR_W-1:2], 2'b00} == `SALP_STAT_OFFSET)
          o_s_axi_bresp <= `SALP_RESP_OKAY;
        else
          o_s_axi_bresp <= `SALP_RESP_SLVERR;
      end
      if (b_hs)
      begin
        o_s_axi_bvalid <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////

  always @*
  begin
    next_rdata = 32'h00000000;
    next_rresp = `SALP_RESP_OKAY;
    if ({i_s_axi_araddr[`SALP_ADDR_W-1:2], 2'b00} == `SALP_PMC_OFFSET)
      next_rdata = pmc_value;
    else if ({i_s_axi_araddr[`SALP_ADDR_W-1:2], 2'b00} == `SALP_STAT_OFFSET)
      next_rdata = stat_value;
    else
      next_rresp = `SALP_RESP_SLVERR;
  end

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= `SALP_RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (ar_hs)
      begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= next_rdata;
        o_s_axi_rresp <= next_rresp;
      end
      else if (r_hs)
      begin
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////

  // A selector change while in low power does not force an exit; only an
  // access wakes the memory, which keeps the power state predictable.
  always @*
  begin
    next_state = state;
    case (state)
      ST_ACTIVE:
      begin
        if (!i_access_pending && sel_on && reached)
          next_state = sel_sr ? ST_SR : ST_PD;
      end
      ST_PD:
      begin
        if (i_access_pending)
          next_state = ST_EXIT;
      end
      ST_SR:
      begin
        if (i_access_pending)
          next_state = ST_EXIT;
      end
      ST_EXIT:
      begin
        if (exit_done)
          next_state = ST_ACTIVE;
      end
      default:
        next_state = ST_ACTIVE;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state <= ST_ACTIVE;
      exit_count <= 4'h0;
      o_cmd_allow <= 1'b1;
      o_powerdown <= 1'b0;
      o_selfrefresh <= 1'b0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      if (next_state == ST_EXIT && state != ST_EXIT)
        exit_count <= EXIT_CYCLES[3:0] - 4'h1;
      else if (!exit_done)
        exit_count <= exit_count - 4'h1;
      o_cmd_allow <= (next_state == ST_ACTIVE);
      o_powerdown <= (next_state == ST_PD);
      o_selfrefresh <= (next_state == ST_SR);
    end
  end

endmodule // salp_top

`default_nettype wire

// ### verification/salp_top_chk.sv
// Checker on salp_top ports: low-power outputs and bus busy flags.
// Assumes one clock domain and a recovery gap of four cycles after a wake;
// the bind below attaches it to every instance.
`timescale 1ns/1ps
`default_nettype none
module salp_top_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic o_s_axi_awready,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_access_pending,
  input wire logic o_cmd_allow,
  input wire logic o_powerdown,
  input wire logic o_selfrefresh
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n || !i_ce);
  wire logic lp = o_powerdown || o_selfrefresh;
  wire logic idle = o_cmd_allow && !i_access_pending;
  // Commands stay blocked for the whole recovery gap after a wake.
  sequence s_exit;
    (!lp && !o_cmd_allow) [*4] ##1 o_cmd_allow;
  endsequence
  chk_one_mode: assert property (!(o_powerdown && o_selfrefresh))
    else $error("both low-power modes high");
  chk_lp_no_cmd: assert property (lp |-> !o_cmd_allow)
    else $error("command allowed in low power");
  chk_pd_entry: assert property ($rose(o_powerdown) |-> $past(idle))
    else $error("power-down entered while busy");
  chk_sr_entry: assert property ($rose(o_selfrefresh) |-> $past(idle))
    else $error("self-refresh entered while busy");
  chk_lp_hold: assert property (lp && !i_access_pending |=> $stable(lp))
    else $error("low power left without access");
  chk_wake_exit: assert property (lp && i_access_pending |=> s_exit)
    else $error("wake-up sequence wrong");
  chk_read_busy: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while answer open");
  chk_write_busy: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken while answer open");
endmodule // salp_top_chk
bind salp_top salp_top_chk salp_top_chk_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
  .o_s_axi_awready(o_s_axi_awready), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_access_pending(i_access_pending),
  .o_cmd_allow(o_cmd_allow), .o_powerdown(o_powerdown), .o_selfrefresh(o_selfrefresh));
`default_nettype wire

// ### verification/salp_mem_model.sv
// Far-side traffic model: the controller's pending-access flag.
// Assumes the bench holds i_req high while it wants traffic.
`timescale 1ns/1ps
`default_nettype none
module salp_mem_model (
  // Clock, request and controller status.
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_cmd_allow,
  // Pending access.
  output var logic o_pending = 1'b0
);
  // An access caught in low power waits until the exit has ended.
  always @(posedge i_clk)
    o_pending <= i_req || (o_pending && !i_cmd_allow);
endmodule // salp_mem_model
`default_nettype wire

// ### verification/salp_top_test.sv
// Bench for salp_top: control register, entry counts, wake-up and reset.
// Assumes EXIT_CYCLES left at four and the traffic model on the far side.
`timescale 1ns/1ps
`default_nettype none
module salp_top_test;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, req = 1'b1;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0, rd;
  wire logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  wire logic o_s_axi_rvalid, o_cmd_allow, o_powerdown, o_selfrefresh, i_access_pending;
  wire logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire logic [31:0] o_s_axi_rdata;
  logic [1:0] resp;
  int error_cnt = 0, checked = 0, n;
  // Control word beside the cycles from the end of traffic to entry.
  logic [31:0] rows [11][2] = '{'{32'h400, 32'h2}, '{32'h1400, 32'h12},
    '{32'hFFFF2CFF, 32'h22}, '{32'h3210, 32'h12}, '{32'h230, 32'h42}, '{32'h0, 32'h12C},
    '{32'h100, 32'h12C}, '{32'h300, 32'h12C}, '{32'h500, 32'h12C}, '{32'h600, 32'h12C},
    '{32'hF00, 32'h12C}};
  salp_top salp_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awprot(3'h0),
    .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wdata(i_s_axi_wdata), .i_s_axi_wstrb(4'hF),
    .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
    .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready), .i_s_axi_araddr(i_s_axi_araddr),
    .i_s_axi_arprot(3'h0), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
    .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
    .i_s_axi_rready(i_s_axi_rready), .i_access_pending(i_access_pending),
    .o_cmd_allow(o_cmd_allow), .o_powerdown(o_powerdown),
    .o_selfrefresh(o_selfrefresh));
  salp_mem_model salp_mem_model_inst (.i_clk(i_clk), .i_req(req), .i_cmd_allow(o_cmd_allow),
    .o_pending(i_access_pending));
  initial forever #4 i_clk = ~i_clk;
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) $display("wrong value %s expected %h seen %h", nm, e, g);
    error_cnt += (g !== e);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_araddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= w;
    i_s_axi_wvalid <= w;
    i_s_axi_bready <= w;
    i_s_axi_arvalid <= !w;
    i_s_axi_rready <= !w;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end
    while (!(o_s_axi_bvalid || o_s_axi_rvalid) && n < 50);
    resp = w ? o_s_axi_bresp : o_s_axi_rresp;
    rd = o_s_axi_rdata;
    i_s_axi_bready <= 1'b0;
    i_s_axi_rready <= 1'b0;
    error_cnt += (n >= 50);
    if (n >= 50) results();
  endtask
  task count(input logic lp, input int lim);
    n = 0;
    do
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    while ((lp ? !(o_powerdown || o_selfrefresh) : !o_cmd_allow) && n < lim);
  endtask
  // A short burst of traffic part-way through the idle wait must restart the count.
  task lp_run(input logic [31:0] c, input logic [31:0] e, input logic [31:0] b);
    bus(1'b1, 8'h00, c);
    bus(1'b0, 8'h00, 32'h0);
    cmp("readback", c & 32'h0000F7F0, rd);
    @(posedge i_clk);
    req <= 1'b0;
    if (b != 32'h0)
    begin
      repeat (b) @(posedge i_clk);
      req <= 1'b1;
      @(posedge i_clk);
      req <= 1'b0;
    end
    count(1'b1, 300);
    cmp("entry cycles", e, n);
    cmp("mode", {c[10:8] == 3'h4, c[10:8] == 3'h2}, {o_powerdown, o_selfrefresh});
    bus(1'b0, 8'h04, 32'h0);
    cmp("status", (c[10:8] == 3'h4) ? 32'h5 : (c[10:8] == 3'h2) ? 32'hA : 32'h10, rd);
    cmp("status response", 32'h0, resp);
    @(posedge i_clk);
    req <= 1'b1;
    count(1'b0, 50);
    cmp("wake cycles", (e < 32'h12C) ? 32'h6 : 32'h1, n);
    if (n >= 50) results();
    $display("test %h done", c);
  endtask
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    cmp("reset value", 32'h0, rd);
    foreach (rows[i])
      lp_run(rows[i][0], rows[i][1], 32'h0);
    lp_run(32'h1400, 32'h12, 32'h8);
    bus(1'b1, 8'h08, 32'hFFFFFFFF);
    cmp("unmapped write", 32'h2, resp);
    bus(1'b0, 8'h0C, 32'h0);
    cmp("unmapped read response", 32'h2, resp);
    cmp("unmapped read data", 32'h0, rd);
    bus(1'b1, 8'h00, 32'h1400);
    cmp("write response", 32'h0, resp);
    @(posedge i_clk);
    req <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_ce <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_ce <= 1'b1;
    count(1'b1, 300);
    cmp("frozen entry cycles", 32'hE, n);
    $display("test clock enable done");
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    cmp("value after reset", 32'h0, rd);
    cmp("low power after reset", 32'h0, {o_powerdown, o_selfrefresh});
    cmp("commands after reset", 32'h1, o_cmd_allow);
    $display("test reset done");
    results();
  end
endmodule // salp_top_test
`default_nettype wire
